// ---- hdl/bru_params.svh ----
// constants of the byte rotate unit: widths, bit positions, codes, resets
`ifndef BRU_PARAMS_SVH
`define BRU_PARAMS_SVH

// ----------------------------------------------------------------------
// datapath geometry
// ----------------------------------------------------------------------
`define BRU_DATA_W      8
`define BRU_MSB         7
`define BRU_LSB         0
`define BRU_OP_W        3

// ----------------------------------------------------------------------
// operation codes presented by the instruction decoder
// ----------------------------------------------------------------------
`define BRU_OP_NONE              3'h0
`define BRU_OP_LEFT_TO_WORK      3'h1
`define BRU_OP_LEFT_FLAG         3'h2
`define BRU_OP_LEFT_FLAG_WORK    3'h3
`define BRU_OP_RIGHT_IN_PLACE    3'h4
`define BRU_OP_RIGHT_TO_WORK     3'h5
`define BRU_OP_RIGHT_FLAG        3'h6
`define BRU_OP_RIGHT_FLAG_WORK   3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BRU_RESULT_RST  8'h00
`define BRU_STROBE_RST  1'b0
`define BRU_CARRY_RST   1'b0

`endif

// ---- hdl/bru_pkg.sv ----
// types shared by the byte rotate unit
`include "bru_params.svh"

package bru_pkg;

    // ------------------------------------------------------------------
    // rotate operations, one per instruction
    // ------------------------------------------------------------------
    typedef enum logic [`BRU_OP_W-1:0] {
        rot_none                       = `BRU_OP_NONE,
        rotate_left_to_work            = `BRU_OP_LEFT_TO_WORK,
        rotate_left_thru_flag          = `BRU_OP_LEFT_FLAG,
        rotate_left_thru_flag_to_work  = `BRU_OP_LEFT_FLAG_WORK,
        rotate_right_in_place          = `BRU_OP_RIGHT_IN_PLACE,
        rotate_right_to_work           = `BRU_OP_RIGHT_TO_WORK,
        rotate_right_thru_flag         = `BRU_OP_RIGHT_FLAG,
        rotate_right_thru_flag_to_work = `BRU_OP_RIGHT_FLAG_WORK
    } bru_op_type;

    typedef logic [`BRU_DATA_W-1:0] bru_byte_type;

endpackage

// ---- hdl/bru_rotate_unit.sv ----
// rotate datapath: seven one-bit rotate instructions on a memory byte
//
// Overview of operation
// RL1: plain left to working register: bit 7 wraps to bit 0, no flags.
// RL2: left through carry in place: old carry to bit 0, bit 7 to carry.
// RL3: left through carry to working register; memory untouched.
// RL4: plain right in place: bit 0 wraps to bit 7, flags unchanged.
// RL5: plain right to working register: bit 0 to bit 7, no flags.
// RL6: right through carry in place: old carry to bit 7, bit 0 to carry.
// RL7: right through carry to working register; memory untouched.
`timescale 1ns/100ps
`include "bru_params.svh"

module bru_rotate_unit
    import bru_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   op_valid,
    input  wire bru_op_type             op_code,
    input  wire logic [`BRU_DATA_W-1:0] mem_rdata,
    input  wire logic                   carry_in,
    output logic      [`BRU_DATA_W-1:0] result_data,
    output logic                        work_we,
    output logic                        mem_we,
    output logic                        carry_we,
    output logic                        carry_data,
    output logic                        op_done
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bru_byte_type result_reg;
    bru_byte_type result_next;
    logic         work_we_reg;
    logic         work_we_next;
    logic         mem_we_reg;
    logic         mem_we_next;
    logic         carry_we_reg;
    logic         carry_we_next;
    logic         carry_reg;
    logic         carry_next;
    logic         done_reg;
    bru_byte_type rot_left;
    bru_byte_type rot_right;
    bru_byte_type thru_left;
    bru_byte_type thru_right;

    // ------------------------------------------------------------------
    // rotate networks, one generate loop over the inner bits
    // ------------------------------------------------------------------
    // inner bits move one place; the edge bits are filled below
    genvar gi;
    generate
        for (gi = 1; gi < `BRU_DATA_W; gi = gi + 1) begin : g_shift
            assign rot_left[gi]       = mem_rdata[gi-1];
            assign thru_left[gi]      = mem_rdata[gi-1];
            assign rot_right[gi-1]    = mem_rdata[gi];
            assign thru_right[gi-1]   = mem_rdata[gi];
        end
    endgenerate

    // RL1: bit 7 wraps
    assign rot_left[`BRU_LSB]    = mem_rdata[`BRU_MSB];
    // RL2: old carry enters
    assign thru_left[`BRU_LSB]   = carry_in;
    // RL4: bit 0 wraps
    assign rot_right[`BRU_MSB]   = mem_rdata[`BRU_LSB];
    // RL6: old carry enters
    assign thru_right[`BRU_MSB]  = carry_in;

    // ------------------------------------------------------------------
    // operation decode: result, destination and carry update
    // ------------------------------------------------------------------
    always_comb begin
        result_next   = result_reg;
        work_we_next  = `BRU_STROBE_RST;
        mem_we_next   = `BRU_STROBE_RST;
        carry_we_next = `BRU_STROBE_RST;
        carry_next    = carry_reg;
        if (op_valid) begin
            case (op_code)
                // RL1: left rotate to work
                rotate_left_to_work: begin
                    result_next  = rot_left;
                    work_we_next = 1'b1;
                end
                // RL2: left through carry back
                rotate_left_thru_flag: begin
                    result_next   = thru_left;
                    mem_we_next   = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next    = mem_rdata[`BRU_MSB];
                end
                // RL3: left through carry work
                rotate_left_thru_flag_to_work: begin
                    result_next   = thru_left;
                    work_we_next  = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next    = mem_rdata[`BRU_MSB];
                end
                // RL4: right rotate back
                rotate_right_in_place: begin
                    result_next = rot_right;
                    mem_we_next = 1'b1;
                end
                // RL5: right rotate to work
                rotate_right_to_work: begin
                    result_next  = rot_right;
                    work_we_next = 1'b1;
                end
                // RL6: right through carry back
                rotate_right_thru_flag: begin
                    result_next   = thru_right;
                    mem_we_next   = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next    = mem_rdata[`BRU_LSB];
                end
                // RL7: right through carry work
                rotate_right_thru_flag_to_work: begin
                    result_next   = thru_right;
                    work_we_next  = 1'b1;
                    carry_we_next = 1'b1;
                    carry_next    = mem_rdata[`BRU_LSB];
                end
                default: begin
                    result_next = result_reg; // idle code: nothing written
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // result byte, held until the next operation
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_reg <= `BRU_RESULT_RST;
        end else begin
            result_reg <= result_next;
        end
    end

    // ------------------------------------------------------------------
    // destination write strobes, one cycle each
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            work_we_reg <= `BRU_STROBE_RST;
            mem_we_reg  <= `BRU_STROBE_RST;
            done_reg    <= `BRU_STROBE_RST;
        end else begin
            work_we_reg <= work_we_next;
            mem_we_reg  <= mem_we_next;
            done_reg    <= op_valid && (op_code != rot_none);
        end
    end

    // ------------------------------------------------------------------
    // carry flag update, only for the through-carry forms
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carry_we_reg <= `BRU_STROBE_RST;
            carry_reg    <= `BRU_CARRY_RST;
        end else begin
            carry_we_reg <= carry_we_next;
            carry_reg    <= carry_next;
        end
    end

    // outputs straight from the flops
    assign result_data = result_reg;
    assign work_we     = work_we_reg;
    assign mem_we      = mem_we_reg;
    assign carry_we    = carry_we_reg;
    assign carry_data  = carry_reg;
    assign op_done     = done_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    function automatic logic is_op(input bru_op_type c, input bru_op_type w);
        is_op = (c == w);
    endfunction

    a_left_work_res: assert property ( // RL1
        op_valid && is_op(op_code, rotate_left_to_work) |=>
            work_we && !mem_we && !carry_we &&
            result_data == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("plain left to work result or strobes wrong");

    a_left_flag_mem: assert property ( // RL2
        op_valid && is_op(op_code, rotate_left_thru_flag) |=>
            mem_we && !work_we && carry_we &&
            carry_data == $past(mem_rdata[7]) &&
            result_data == {$past(mem_rdata[6:0]), $past(carry_in)})
        else $error("left through carry in place wrong");

    a_left_flag_work: assert property ( // RL3
        op_valid && is_op(op_code, rotate_left_thru_flag_to_work) |=>
            work_we && !mem_we && carry_we &&
            carry_data == $past(mem_rdata[7]) &&
            result_data == {$past(mem_rdata[6:0]), $past(carry_in)})
        else $error("left through carry to work wrong");

    a_right_place_res: assert property ( // RL4
        op_valid && is_op(op_code, rotate_right_in_place) |=>
            mem_we && !work_we && !carry_we && $stable(carry_data) &&
            result_data == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("plain right in place wrong");

    a_right_work_res: assert property ( // RL5
        op_valid && is_op(op_code, rotate_right_to_work) |=>
            work_we && !mem_we && !carry_we &&
            result_data == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("plain right to work wrong");

    a_right_flag_mem: assert property ( // RL6
        op_valid && is_op(op_code, rotate_right_thru_flag) |=>
            mem_we && !work_we && carry_we &&
            carry_data == $past(mem_rdata[0]) &&
            result_data == {$past(carry_in), $past(mem_rdata[7:1])})
        else $error("right through carry in place wrong");

    a_right_flag_work: assert property ( // RL7
        op_valid && is_op(op_code, rotate_right_thru_flag_to_work) |=>
            work_we && !mem_we && carry_we &&
            carry_data == $past(mem_rdata[0]) &&
            result_data == {$past(carry_in), $past(mem_rdata[7:1])})
        else $error("right through carry to work wrong");

    a_carry_held: assert property ( // every cycle without a carry update
        !carry_we |-> $stable(carry_data) or $rose(carry_we) or
            $past(rst))
        else $error("carry changed without a carry update");

    a_idle_quiet: assert property (
        !op_valid |=> !work_we && !mem_we && !carry_we && !op_done
            && $stable(result_data))
        else $error("strobe or result moved with no operation");

    c_back_to_back: cover property (
        op_valid && is_op(op_code, rotate_left_thru_flag) ##1
        op_valid && is_op(op_code, rotate_right_thru_flag));
    c_carry_set: cover property (carry_we && carry_data);
    c_work_write: cover property (work_we && carry_we);
    c_mem_write: cover property (mem_we && !carry_we);

endmodule

// ---- test/bru_partner_model.sv ----
// data memory, working register and carry flag model facing the byte rotate unit
`timescale 1ns/100ps

module bru_partner_model
    import bru_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         load_en,
    input  wire bru_byte_type load_byte,
    input  wire logic         load_carry,
    input  wire bru_byte_type result_data,
    input  wire logic         work_we,
    input  wire logic         mem_we,
    input  wire logic         carry_we,
    input  wire logic         carry_data,
    output bru_byte_type      mem_reg,
    output bru_byte_type      work_reg,
    output logic              carry_reg
);
    // memory byte, working register and carry flag follow the strobes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_reg   <= 8'h00;
            work_reg  <= 8'h00;
            carry_reg <= 1'h0;
        end else if (load_en) begin
            mem_reg   <= load_byte;
            work_reg  <= 8'h5A;     // marker that shows a missed write
            carry_reg <= load_carry;
        end else begin
            if (mem_we) mem_reg <= result_data;
            if (work_we) work_reg <= result_data;
            if (carry_we) carry_reg <= carry_data;
        end
    end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the byte rotate unit
`timescale 1ns/100ps

module testbench
    import bru_pkg::*;
;
    logic         core_clk, rst, op_valid, load_en, load_carry;
    bru_op_type   op_code;
    bru_byte_type load_byte, mem_reg, work_reg, result_data;
    logic         carry_reg, work_we, mem_we, carry_we, carry_data, op_done;
    logic [3:0]   seen_strb, seen_after;
    int           fail_count, checks, cycle_count;

    bru_rotate_unit u_dut (.core_clk(core_clk), .rst(rst),
        .op_valid(op_valid), .op_code(op_code), .mem_rdata(mem_reg),
        .carry_in(carry_reg), .result_data(result_data),
        .work_we(work_we), .mem_we(mem_we), .carry_we(carry_we),
        .carry_data(carry_data), .op_done(op_done));

    bru_partner_model u_partner (.core_clk(core_clk), .rst(rst),
        .load_en(load_en), .load_byte(load_byte), .load_carry(load_carry),
        .result_data(result_data), .work_we(work_we), .mem_we(mem_we),
        .carry_we(carry_we), .carry_data(carry_data), .mem_reg(mem_reg),
        .work_reg(work_reg), .carry_reg(carry_reg));

    // clock, 25 ns period
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // seed the operand, issue one op, capture strobes then let it land
    task automatic run_op(input bru_op_type code, input bru_byte_type b,
                          input logic c);
        @(posedge core_clk);
        load_en <= 1'h1;
        load_byte <= b;
        load_carry <= c;
        @(posedge core_clk);
        load_en <= 1'h0;
        op_valid <= 1'h1;
        op_code <= code;
        @(posedge core_clk);
        op_valid <= 1'h0;
        op_code <= rot_none;
        // strobes stand from this edge to the next one only
        @(negedge core_clk);
        seen_strb = {op_done, work_we, mem_we, carry_we};
        @(negedge core_clk);
        seen_after = {op_done, work_we, mem_we, carry_we};
    endtask

    // strobes are {done, work, mem, carry}
    task automatic expect_all(input bru_byte_type m, input bru_byte_type w,
                              input logic c, input logic [3:0] s);
        check(mem_reg, m);
        check(work_reg, w);
        check(carry_reg, c);
        check(seen_strb, s);
        check(seen_after, 4'h0);
    endtask

    task automatic t_left_work;
        run_op(rotate_left_to_work, 8'h81, 1'h0);
        expect_all(8'h81, 8'h03, 1'h0, 4'hC);
        run_op(rotate_left_to_work, 8'h7E, 1'h1);
        expect_all(8'h7E, 8'hFC, 1'h1, 4'hC);
    endtask

    task automatic t_left_flag;
        run_op(rotate_left_thru_flag, 8'h80, 1'h0);
        expect_all(8'h00, 8'h5A, 1'h1, 4'hB);
        run_op(rotate_left_thru_flag, 8'h7F, 1'h1);
        expect_all(8'hFF, 8'h5A, 1'h0, 4'hB);
    endtask

    task automatic t_left_flag_work;
        run_op(rotate_left_thru_flag_to_work, 8'h80, 1'h1);
        expect_all(8'h80, 8'h01, 1'h1, 4'hD);
    endtask

    task automatic t_right_place;
        run_op(rotate_right_in_place, 8'h01, 1'h0);
        expect_all(8'h80, 8'h5A, 1'h0, 4'hA);
    endtask

    task automatic t_right_work;
        run_op(rotate_right_to_work, 8'hFE, 1'h1);
        expect_all(8'hFE, 8'h7F, 1'h1, 4'hC);
    endtask

    task automatic t_right_flag;
        run_op(rotate_right_thru_flag, 8'h81, 1'h0);
        expect_all(8'h40, 8'h5A, 1'h1, 4'hB);
    endtask

    task automatic t_right_flag_work;
        run_op(rotate_right_thru_flag_to_work, 8'h02, 1'h1);
        expect_all(8'h02, 8'h81, 1'h0, 4'hD);
    endtask

    task automatic t_idle_code;
        run_op(rot_none, 8'h3C, 1'h1);
        expect_all(8'h3C, 8'h5A, 1'h1, 4'h0);
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 1000) begin
            fail_count = fail_count + 1;
            finish_test();
        end
    end

    // reset then scenarios
    initial begin
        fail_count = 0;
        checks = 0;
        cycle_count = 0;
        rst = 1'h1;
        op_valid = 1'h0;
        op_code = rot_none;
        load_en = 1'h0;
        load_byte = 8'h00;
        load_carry = 1'h0;
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        t_left_work();
        t_left_flag();
        t_left_flag_work();
        t_right_place();
        t_right_work();
        t_right_flag();
        t_right_flag_work();
        t_idle_code();
        finish_test();
    end
endmodule
